// ===== wrc_pkg.sv
// constants for the warm reset and clock select block
// assumes one 10 MHz system clock that is also the undivided high-speed clock
// How it works
// - a warm reset leaves debug state, reset cause flags and the flash security bit alone.
// - after any reset the multiplier stays off until software enables it in pll selection.
// - when the reset sequence ends the core is released to fetch from its reset handler.
// - internal memory contents need not survive a reset.
// - six word registers decode at offsets 0x00, 0x04, 0x08, 0x0C, 0x10 and 0x14.
// - system control bits 17-16 pick low-speed, half system, system or prescaler clock for the clock output.
// - system control bit 12 picks the geared clock (0) or the undivided high-speed clock (1) as peripheral source.
// - bits 10-8 divide the peripheral clock by 1, 2, 4, 8, 16 or 32; codes 110 and 111 are reserved.
// - bits 2-0 set the gear: 000 undivided, 100 by 2, 101 by 4, 110 by 8, others reserved.
// - reset pin, watchdog and the core software reset request all cause a warm reset.
`default_nettype none
package wrc_pkg;
   localparam int unsigned SYS_CLK_HZ   = 10_000_000;
   localparam int unsigned RST_MIN_SYSCLK = 12;
   localparam int unsigned RST_MIN_CYCLES = RST_MIN_SYSCLK;

   localparam logic [7:0] OFF_SYSCTL  = 8'h00;
   localparam logic [7:0] OFF_OSCCTL  = 8'h04;
   localparam logic [7:0] OFF_STBYCTL = 8'h08;
   localparam logic [7:0] OFF_PLLSEL  = 8'h0C;
   localparam logic [7:0] OFF_CKSEL   = 8'h10;
   localparam logic [7:0] OFF_CAUSE   = 8'h14;

   localparam int unsigned CO_SEL_LSB  = 16;
   localparam int unsigned PERIPH_SOURCE_SELECT_BIT   = 12;
   localparam int unsigned PRESCALER_DIVIDE_LSB    = 8;
   localparam int unsigned GEAR_LSB    = 0;
   localparam int unsigned PLL_EN_BIT  = 0;
   localparam int unsigned FLASH_SEC_BIT = 8;

   localparam logic [31:0] SYSCTL_RST  = 32'h0001_0000;
   localparam logic [31:0] SYSCTL_WM   = 32'h0003_1707;
   localparam logic [31:0] OSCCTL_RST  = 32'h0000_0310;
   localparam logic [31:0] OSCCTL_WM   = 32'h0000_337C;
   localparam logic [31:0] STBYCTL_RST = 32'h0000_0103;
   localparam logic [31:0] STBYCTL_WM  = 32'h0003_0307;
   localparam logic [31:0] PLLSEL_RST  = 32'h0000_0000;
   localparam logic [31:0] CKSEL_RST   = 32'h0000_0000;

   localparam logic [2:0] GEAR_DIV1 = 3'h0;
   localparam logic [2:0] GEAR_DIV2 = 3'h4;
   localparam logic [2:0] GEAR_DIV4 = 3'h5;
   localparam logic [2:0] GEAR_DIV8 = 3'h6;
   localparam logic [2:0] PRESCALER_DIVIDE_MAX  = 3'h5;

   localparam logic [1:0] CO_LOW_SPEED = 2'h0;
   localparam logic [1:0] CO_SYS_HALF  = 2'h1;
   localparam logic [1:0] CO_SYS       = 2'h2;
   localparam logic [1:0] CO_PRESC     = 2'h3;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      WRC_RUN     = 2'h0,
      WRC_HOLD    = 2'h1,
      WRC_RELEASE = 2'h3
   } wrc_state_t;
endpackage
`default_nettype wire

// ===== wrc_top.sv
// warm reset sequencer, clock gear, prescaler and clock output select, AXI4-Lite registers
// assumes aresetn is the cold reset; watchdog and software requests come from aclk logic
`default_nettype none
module wrc_top (
   // clock and cold reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // reset sources and low-speed clock
   input  wire logic        reset_pin_n,
   input  wire logic        wdt_reset_req,
   input  wire logic        software_system_reset_request,
   input  wire logic        low_speed_clock,
   // AXI4-Lite write
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // AXI4-Lite read
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // reset and clock outputs
   output logic             core_reset_n,
   output logic             reset_vector_fetch,
   output logic             pll_enable,
   output logic             gear_tick,
   output logic             periph_tick,
   output logic             presc_tick,
   output logic             clock_out_pin
);
   import wrc_pkg::*;

   function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] dat,
                                            input logic [3:0] strb, input logic [31:0] wm);
      logic [31:0] be;
      be = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wm;
      return (old & ~be) | (dat & be);
   endfunction

   function automatic logic [2:0] gear_mask(input logic [2:0] code);
      case (code)
         GEAR_DIV2: return 3'h1;
         GEAR_DIV4: return 3'h3;
         GEAR_DIV8: return 3'h7;
         default:   return 3'h0;
      endcase
   endfunction

   function automatic logic gear_ok(input logic [2:0] code);
      return code == GEAR_DIV1 || code == GEAR_DIV2 || code == GEAR_DIV4 || code == GEAR_DIV8;
   endfunction

   // pin and low-speed clock synchronisers
   logic       pin_s1_q, pin_s2_q;
   logic       lsc_s1_q, lsc_s2_q, lsc_s3_q;
   always_ff @(posedge aclk) begin
      pin_s1_q <= reset_pin_n;
      pin_s2_q <= pin_s1_q;
      lsc_s1_q <= low_speed_clock;
      lsc_s2_q <= lsc_s1_q;
      lsc_s3_q <= lsc_s2_q;
   end

   // warm reset sequencer
   wrc_state_t state_q;
   logic [3:0] low_cnt_q;
   logic       pin_warm, trig;
   assign pin_warm = (low_cnt_q >= 4'(RST_MIN_CYCLES));
   assign trig = pin_warm || wdt_reset_req || software_system_reset_request;

   always_ff @(posedge aclk) begin
      if (!aresetn || pin_s2_q) begin
         low_cnt_q <= 4'h0;
      end else if (!pin_warm) begin
         low_cnt_q <= low_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= WRC_HOLD;
      end else begin
         case (state_q)
            WRC_RUN:     if (trig) state_q <= WRC_HOLD;
            WRC_HOLD:    if (!trig && pin_s2_q) state_q <= WRC_RELEASE;
            WRC_RELEASE: state_q <= trig ? WRC_HOLD : WRC_RUN;
            default:     state_q <= WRC_HOLD;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_reset_n       <= 1'b0;
         reset_vector_fetch <= 1'b0;
      end else begin
         core_reset_n       <= (state_q != WRC_HOLD);
         reset_vector_fetch <= (state_q == WRC_RELEASE);
      end
   end

   // registers; warm reset clears all but the cause register
   // memory left as it is
   logic        regs_rst;
   logic [31:0] sysctl_q, oscctl_q, stbyctl_q, pllsel_q, cksel_q;
   logic [2:0]  cause_q;
   logic        flash_sec_q;
   logic        aw_have_q, w_have_q, do_wr;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   assign regs_rst = !aresetn || (state_q == WRC_HOLD);
   assign do_wr    = aw_have_q && w_have_q && !bvalid;

   always_ff @(posedge aclk) begin
      if (regs_rst) begin
         sysctl_q  <= SYSCTL_RST;
         oscctl_q  <= OSCCTL_RST;
         stbyctl_q <= STBYCTL_RST;
         pllsel_q  <= PLLSEL_RST;
         cksel_q   <= CKSEL_RST;
      end else if (do_wr) begin
         case (awaddr_q)
            OFF_SYSCTL:  sysctl_q  <= wr_merge(sysctl_q, wdata_q, wstrb_q, SYSCTL_WM);
            OFF_OSCCTL:  oscctl_q  <= wr_merge(oscctl_q, wdata_q, wstrb_q, OSCCTL_WM);
            OFF_STBYCTL: stbyctl_q <= wr_merge(stbyctl_q, wdata_q, wstrb_q, STBYCTL_WM);
            OFF_PLLSEL:  pllsel_q  <= wr_merge(pllsel_q, wdata_q, wstrb_q, 32'hFFFF_FFFF);
            OFF_CKSEL:   cksel_q   <= wr_merge(cksel_q, wdata_q, wstrb_q, 32'hFFFF_FFFF);
            default:     ;
         endcase
      end
   end

   // cold reset only; a new cause beats a clear
   logic        cause_clr;
   logic [2:0]  cause_set;
   assign cause_clr = do_wr && (awaddr_q == OFF_CAUSE) && wstrb_q[0];
   assign cause_set = {software_system_reset_request, wdt_reset_req, pin_warm};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cause_q     <= 3'h0;
         flash_sec_q <= 1'b0;
      end else begin
         cause_q <= (cause_clr ? (cause_q & ~wdata_q[2:0]) : cause_q) | cause_set;
         if (do_wr && awaddr_q == OFF_CAUSE && wstrb_q[1] && wdata_q[FLASH_SEC_BIT]) begin
            flash_sec_q <= 1'b1;
         end
      end
   end

   // write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awready   <= 1'b1;
         wready    <= 1'b1;
         bvalid    <= 1'b0;
         bresp     <= RESP_OKAY;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            awready   <= 1'b0;
            awaddr_q  <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_q <= 1'b1;
            wready   <= 1'b0;
            wdata_q  <= wdata;
            wstrb_q  <= wstrb;
         end
         if (do_wr) begin
            bvalid <= 1'b1;
            bresp  <= (awaddr_q[1:0] == 2'h0 && awaddr_q <= OFF_CAUSE) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid    <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready   <= 1'b1;
            wready    <= 1'b1;
         end
      end
   end

   // read channel
   logic [31:0] rd_val;
   logic [1:0]  rd_resp;
   always_comb begin
      rd_resp = RESP_OKAY;
      case (araddr)
         OFF_SYSCTL:  rd_val = sysctl_q;
         OFF_OSCCTL:  rd_val = oscctl_q;
         OFF_STBYCTL: rd_val = stbyctl_q;
         OFF_PLLSEL:  rd_val = pllsel_q;
         OFF_CKSEL:   rd_val = cksel_q;
         OFF_CAUSE:   rd_val = {23'h0, flash_sec_q, 5'h0, cause_q};
         default: begin
            rd_val  = 32'h0000_0000;
            rd_resp = RESP_SLVERR;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rd_val;
         rresp   <= rd_resp;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // clock dividers; selections copied to shadows only at a common boundary
   logic [2:0] gear_cnt_q, gear_sh_q, prescaler_divide_sh_q;
   logic [4:0] presc_cnt_q;
   logic [1:0] co_sel_sh_q;
   logic       periph_source_select_sh_q, half_q, sync_pt;
   logic       gear_en, periph_en, presc_en, co_en;
   logic [4:0] pmask;
   assign sync_pt   = (gear_cnt_q == 3'h0) && (presc_cnt_q == 5'h00);
   assign gear_en   = (gear_cnt_q & gear_mask(gear_sh_q)) == 3'h0;
   assign periph_en = periph_source_select_sh_q || gear_en;
   assign pmask     = 5'((6'h01 << prescaler_divide_sh_q) - 6'h01);
   assign presc_en  = periph_en && ((presc_cnt_q & pmask) == 5'h00);

   always_ff @(posedge aclk) begin
      if (regs_rst) begin
         gear_cnt_q  <= 3'h0;
         presc_cnt_q <= 5'h00;
         half_q      <= 1'b0;
      end else begin
         gear_cnt_q <= gear_cnt_q + 3'h1;
         if (periph_en) presc_cnt_q <= presc_cnt_q + 5'h01;
         if (gear_en) half_q <= !half_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (regs_rst) begin
         gear_sh_q   <= SYSCTL_RST[GEAR_LSB +: 3];
         prescaler_divide_sh_q   <= SYSCTL_RST[PRESCALER_DIVIDE_LSB +: 3];
         periph_source_select_sh_q  <= SYSCTL_RST[PERIPH_SOURCE_SELECT_BIT];
         co_sel_sh_q <= SYSCTL_RST[CO_SEL_LSB +: 2];
      end else if (sync_pt) begin
         // reserved codes keep the previous setting
         if (gear_ok(sysctl_q[GEAR_LSB +: 3])) gear_sh_q <= sysctl_q[GEAR_LSB +: 3];
         if (sysctl_q[PRESCALER_DIVIDE_LSB +: 3] <= PRESCALER_DIVIDE_MAX) prescaler_divide_sh_q <= sysctl_q[PRESCALER_DIVIDE_LSB +: 3];
         periph_source_select_sh_q  <= sysctl_q[PERIPH_SOURCE_SELECT_BIT];
         co_sel_sh_q <= sysctl_q[CO_SEL_LSB +: 2];
      end
   end

   always_comb begin
      case (co_sel_sh_q)
         CO_LOW_SPEED: co_en = lsc_s2_q && !lsc_s3_q;
         CO_SYS_HALF:  co_en = gear_en && half_q;
         CO_SYS:       co_en = gear_en;
         default:      co_en = presc_en;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (regs_rst) begin
         gear_tick     <= 1'b0;
         periph_tick   <= 1'b0;
         presc_tick    <= 1'b0;
         clock_out_pin <= 1'b0;
         pll_enable    <= 1'b0;
      end else begin
         gear_tick     <= gear_en;
         periph_tick   <= periph_en;
         presc_tick    <= presc_en;
         clock_out_pin <= co_en;
         pll_enable    <= pllsel_q[PLL_EN_BIT];
      end
   end

   // checks
   sequence s_fetch;
      reset_vector_fetch && core_reset_n;
   endsequence

   property p_cold_only;
      @(posedge aclk) disable iff (!aresetn) (state_q == WRC_HOLD) |=> flash_sec_q == $past(flash_sec_q);
   endproperty
   a_cold_only: assert property (p_cold_only) else $error("warm reset changed flash security");

   property p_pll_off;
      @(posedge aclk) disable iff (!aresetn) (state_q == WRC_HOLD) |=> ##1 !pll_enable;
   endproperty
   a_pll_off: assert property (p_pll_off) else $error("pll enabled after reset");

   property p_fetch;
      @(posedge aclk) disable iff (!aresetn) (state_q == WRC_RELEASE) |=> s_fetch;
   endproperty
   a_fetch: assert property (p_fetch) else $error("no handler fetch on release");

   property p_decode;
      @(posedge aclk) disable iff (!aresetn)
         (arvalid && arready && araddr == OFF_PLLSEL) |=> rvalid && rdata == $past(pllsel_q) && rresp == RESP_OKAY;
   endproperty
   a_decode: assert property (p_decode) else $error("pll selection read wrong");

   property p_co_sys;
      @(posedge aclk) disable iff (!aresetn)
         (co_sel_sh_q == CO_SYS && gear_sh_q == GEAR_DIV1 && !regs_rst) |=> clock_out_pin;
   endproperty
   a_co_sys: assert property (p_co_sys) else $error("clock out not system clock");

   property p_fc_periph;
      @(posedge aclk) disable iff (!aresetn) (periph_source_select_sh_q && !regs_rst) |=> periph_tick;
   endproperty
   a_fc_periph: assert property (p_fc_periph) else $error("peripheral clock not undivided");

   property p_presc;
      @(posedge aclk) disable iff (!aresetn) (presc_tick && prescaler_divide_sh_q != 3'h0) |=> !presc_tick;
   endproperty
   a_presc: assert property (p_presc) else $error("prescaler tick too close");

   property p_gear8;
      @(posedge aclk) disable iff (regs_rst) (gear_tick && gear_sh_q == GEAR_DIV8) |=> !gear_tick [*7];
   endproperty
   a_gear8: assert property (p_gear8) else $error("gear by 8 spacing wrong");

   property p_wdt;
      @(posedge aclk) disable iff (!aresetn) (wdt_reset_req && state_q == WRC_RUN) |=> ##1 !core_reset_n;
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog did not reset core");

   property p_glitch;
      @(posedge aclk) disable iff (regs_rst) $changed(gear_sh_q) |-> $past(sync_pt) || $past(regs_rst);
   endproperty
   a_glitch: assert property (p_glitch) else $error("gear switched off boundary");
endmodule // wrc_top
`default_nettype wire

// ===== warm_reset_and_clock_select_test.sv
// self-checking bench for wrc_top: register map, warm reset sources, divider rates
// assumes wrc_pkg and wrc_top are compiled first; bench drives every port itself
`default_nettype none
module warm_reset_and_clock_select_test;
   timeunit 1ns;
   timeprecision 1ns;
   import wrc_pkg::*;

   logic        aclk = 1'h0, aresetn = 1'h0, reset_pin_n = 1'h1, wdt_reset_req = 1'h0;
   logic        software_system_reset_request = 1'h0, low_speed_clock = 1'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        awready, wready, bvalid, arready, rvalid, core_reset_n, reset_vector_fetch;
   logic        pll_enable, gear_tick, periph_tick, presc_tick, clock_out_pin;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [31:0] mdl [6];
   logic [31:0] cfg [7] = '{32'h0002_0300, 32'h0001_0004, 32'h0003_1505, 32'h0000_0106,
                            32'h0002_1206, 32'h0002_1401, 32'h0003_1607};
   int          error_cnt = 0, cmp_count = 0, fetch_cnt = 0, ls_cnt = 0, seed, g_div, p_div;

   wrc_top DUT (.aclk, .aresetn, .reset_pin_n, .wdt_reset_req, .software_system_reset_request,
      .low_speed_clock, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .core_reset_n,
      .reset_vector_fetch, .pll_enable, .gear_tick, .periph_tick, .presc_tick, .clock_out_pin);

   always #50 aclk = ~aclk;

   // low-speed source: period 24 system clocks
   always @(posedge aclk) begin
      if (reset_vector_fetch === 1'h1) fetch_cnt <= fetch_cnt + 1;
      ls_cnt <= (ls_cnt == 11) ? 0 : ls_cnt + 1;
      if (ls_cnt == 11) low_speed_clock <= ~low_speed_clock;
   end

   function automatic logic pick(input int s);
      case (s)
         0: return gear_tick;
         1: return periph_tick;
         2: return presc_tick;
         3: return clock_out_pin;
         default: return core_reset_n;
      endcase
   endfunction

   // expected tick spacing from the model's settings
   function automatic int period(input int s);
      int pf, pr;
      pf = mdl[0][12] ? 1 : g_div;
      pr = pf * p_div;
      case (s)
         0: return g_div;
         1: return pf;
         2: return pr;
         default: case (mdl[0][17:16])
            2'h0: return 24;
            2'h1: return 2 * g_div;
            2'h2: return g_div;
            default: return pr;
         endcase
      endcase
   endfunction

   task automatic reset_model(input logic [31:0] keep);
      mdl = '{SYSCTL_RST, OSCCTL_RST, STBYCTL_RST, PLLSEL_RST, CKSEL_RST, keep};
      g_div = 1;
      p_div = 1;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic hang();
      error_cnt++;
      $display("mismatch at %0t: wait ran out", $time);
      finish_test();
   endtask

   task automatic wait_for(input int s, input logic v, input int lim);
      int n;
      n = 0;
      do @(posedge aclk) n++; while (pick(s) !== v && n < lim);
      if (pick(s) !== v) hang();
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic aw_p, w_p;
      n = 0;
      aw_p = 1'h1;
      w_p = 1'h1;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while ((aw_p || w_p) && n < 50) begin
         @(posedge aclk) n++;
         if (aw_p && awready === 1'h1) begin
            aw_p = 1'h0;
            awvalid <= 1'h0;
         end
         if (w_p && wready === 1'h1) begin
            w_p = 1'h0;
            wvalid <= 1'h0;
         end
      end
      do @(posedge aclk) n++; while (bvalid !== 1'h1 && n < 100);
      bready <= 1'h0;
      if (bvalid !== 1'h1) hang();
      chk({30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
   endtask

   task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge aclk) n++; while (arready !== 1'h1 && n < 50);
      arvalid <= 1'h0;
      do @(posedge aclk) n++; while (rvalid !== 1'h1 && n < 100);
      rready <= 1'h0;
      if (rvalid !== 1'h1) hang();
      chk(rdata, ed);
      chk({30'h0, rresp}, {30'h0, er});
      @(posedge aclk);
   endtask

   // reserved gear and prescaler codes are stored but leave the rate alone
   task automatic reg_wr(input int i, input logic [31:0] d);
      logic [31:0] m;
      m = (i == 0) ? SYSCTL_WM : (i == 1) ? OSCCTL_WM : (i == 2) ? STBYCTL_WM : 32'hFFFF_FFFF;
      if (i == 5) mdl[5] = (mdl[5] & ~(d & 32'h0000_0007)) | (d & 32'h0000_0100);
      else mdl[i] = (mdl[i] & ~m) | (d & m);
      if (i == 0 && d[2:0] == 3'h0) g_div = 1;
      if (i == 0 && d[2:0] >= 3'h4 && d[2:0] <= 3'h6) g_div = 2 ** (int'(d[2:0]) - 3);
      if (i == 0 && d[10:8] <= PRESCALER_DIVIDE_MAX) p_div = 2 ** int'(d[10:8]);
      axi_write(8'(4 * i), d, RESP_OKAY);
   endtask

   task automatic reg_rd(input int i);
      axi_read(8'(4 * i), mdl[i], RESP_OKAY);
   endtask

   task automatic measure(input int s);
      int n;
      repeat (300) @(posedge aclk);
      wait_for(s, 1'h1, 600);
      n = 0;
      do @(posedge aclk) n++; while (pick(s) !== 1'h1 && n < 600);
      chk(32'(n), 32'(period(s)));
   endtask

   // src 0 pin, 1 watchdog, 2 software request
   task automatic warm(input int src, input int len);
      int f;
      f = fetch_cnt;
      if (src == 0) reset_pin_n <= 1'h0;
      if (src == 1) wdt_reset_req <= 1'h1;
      if (src == 2) software_system_reset_request <= 1'h1;
      repeat (len) @(posedge aclk);
      reset_pin_n <= 1'h1;
      wdt_reset_req <= 1'h0;
      software_system_reset_request <= 1'h0;
      if (src == 0 && len < 12) begin
         repeat (40) @(posedge aclk);
         chk({31'h0, core_reset_n}, 32'h1);
         chk(32'(fetch_cnt), 32'(f));
      end else begin
         wait_for(4, 1'h0, 40);
         wait_for(4, 1'h1, 40);
         repeat (2) @(posedge aclk);
         chk(32'(fetch_cnt), 32'(f + 1));
         chk({31'h0, pll_enable}, 32'h0);
         reset_model(mdl[5] | (32'h1 << src));
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      seed = 97756;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      reset_model(32'h0);
      wait_for(4, 1'h1, 20);
      repeat (2) @(posedge aclk);
      chk(32'(fetch_cnt), 32'h1);
      for (int i = 0; i < 6; i++) reg_rd(i);
      axi_write(8'h18, 32'hFFFF_FFFF, RESP_SLVERR);
      axi_read(8'h02, 32'h0, RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin
         reg_wr(i, $random(seed));
         reg_rd(i);
      end
      chk({31'h0, pll_enable}, {31'h0, mdl[3][0]});
      for (int k = 0; k < 7; k++) begin
         reg_wr(0, cfg[k]);
         reg_rd(0);
         for (int s = 0; s < 4; s++) measure(s);
      end
      reg_wr(5, 32'h0000_0100);
      for (int src = 0; src < 3; src++) begin
         reg_wr(3, 32'h0000_0001);
         reg_wr(0, cfg[2]);
         warm(src, 12);
         for (int i = 0; i < 6; i++) reg_rd(i);
         measure(0);
         measure(3);
         reg_wr(5, 32'h0000_0007);
         reg_rd(5);
      end
      warm(0, 11);
      aresetn <= 1'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      reset_model(32'h0);
      wait_for(4, 1'h1, 20);
      reg_rd(5);
      finish_test();
   end
endmodule // warm_reset_and_clock_select_test
`default_nettype wire
